// [inc/mvst_map.svh]
// constants for the multimode valley switching timer
`ifndef MVST_MAP_SVH
`define MVST_MAP_SVH
`define MVST_IDX_MIN 4'h1
`define MVST_IDX_MAX 4'hA
`define MVST_IDX_RST 4'h1
`define MVST_ONE16 16'h0001
`define MVST_ZERO16 16'h0000
`endif

// [inc/mvst_pkg.sv]
// types for the multimode valley switching timer
package mvst_pkg;
  typedef enum logic [1:0]
  {
    MVST_IDLE = 2'b00,
    MVST_ON = 2'b01,
    MVST_OFF = 2'b10,
    MVST_QTR = 2'b11
  } mvst_state_t;
endpackage : mvst_pkg

// [core/mvst_timer.sv]
// valley switching cycle timer with frequency law
`timescale 1ns/10ps
`include "mvst_map.svh"
module mvst_timer
  import mvst_pkg::*;
#(
  parameter int CW = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [CW-1:0] on_time,
  input wire logic [CW-1:0] max_period,
  input wire logic [CW-1:0] min_period,
  input wire logic [CW-1:0] quarter_osc,
  input wire logic zero_crossing_detect,
  output logic gate,
  output logic [3:0] valley_index,
  output logic first_valley_operation
);
  // ************************************************************
  // input synchroniser, three stages
  // ************************************************************
  logic [2:0] zcd_sync_reg;
  logic zcd_lvl_reg;
  logic [2:0] zcd_sync_next;
  logic zcd_lvl_next;
  logic zcd_fall;
  always_comb
  begin
    zcd_sync_next = {zcd_sync_reg[1:0], zero_crossing_detect};
    zcd_lvl_next = zcd_lvl_reg;
    // stage one feeds only stage two; stages two and three must agree
    if (zcd_sync_reg[2] == zcd_sync_reg[1])
    begin
      zcd_lvl_next = zcd_sync_reg[1];
    end
  end
  assign zcd_fall = zcd_lvl_reg & ~zcd_lvl_next;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zcd_sync_reg <= 3'h0;
      zcd_lvl_reg <= 1'b0;
    end
    else
    begin
      zcd_sync_reg <= zcd_sync_next;
      zcd_lvl_reg <= zcd_lvl_next;
    end
  end

  // ************************************************************
  // switching cycle sequencer
  // ************************************************************
  mvst_state_t state_reg, state_next;
  logic [CW-1:0] tmr_reg, tmr_next;
  logic [CW-1:0] per_reg, per_next;
  logic [3:0] edges_reg, edges_next;
  logic [3:0] idx_reg, idx_next;
  logic gate_reg, gate_next;
  logic start;
  logic per_end;
  assign per_end = (per_reg + `MVST_ONE16) >= max_period;
  always_comb
  begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    per_next = per_reg + `MVST_ONE16;
    edges_next = edges_reg;
    idx_next = idx_reg;
    gate_next = 1'b0;
    start = 1'b0;
    case (state_reg)
      MVST_IDLE:
      begin
        per_next = `MVST_ZERO16;
        if (enable)
        begin
          start = 1'b1;
        end
      end
      MVST_ON:
      begin
        gate_next = 1'b1;
        tmr_next = tmr_reg + `MVST_ONE16;
        // same on_time every cycle, off-time alone varies
        if (tmr_reg + `MVST_ONE16 >= on_time)
        begin
          gate_next = 1'b0;
          state_next = MVST_OFF;
          edges_next = 4'h0;
        end
      end
      MVST_OFF:
      begin
        if (zcd_fall)
        begin
          edges_next = edges_reg + 4'h1;
          // index one: first fall means current reached zero
          if (edges_reg + 4'h1 >= idx_reg)
          begin
            state_next = MVST_QTR;
            tmr_next = `MVST_ZERO16;
          end
        end
        if (per_end)
        begin
          start = 1'b1;
        end
      end
      MVST_QTR:
      begin
        tmr_next = tmr_reg + `MVST_ONE16;
        if (tmr_reg + `MVST_ONE16 >= quarter_osc || per_end)
        begin
          start = 1'b1;
        end
      end
      default:
      begin
        state_next = MVST_IDLE;
      end
    endcase
    if (start)
    begin
      // frequency law judged on the period just ended
      if (state_reg != MVST_IDLE)
      begin
        if (per_reg + `MVST_ONE16 >= min_period)
        begin
          if (idx_reg > `MVST_IDX_MIN)
          begin
            idx_next = idx_reg - 4'h1;
          end
        end
      end
      state_next = enable ? MVST_ON : MVST_IDLE;
      gate_next = enable;
      tmr_next = `MVST_ZERO16;
      per_next = `MVST_ZERO16;
    end
    if (!enable)
    begin
      state_next = MVST_IDLE;
      gate_next = 1'b0;
    end
  end
  // shortest period a valley can give: on-time plus half a ring period
  logic [CW-1:0] fmax_period;
  assign fmax_period = on_time + quarter_osc + quarter_osc;
  // valley came sooner than that: frequency at its upper bound
  logic fast_cycle;
  assign fast_cycle = start && state_reg == MVST_QTR && !per_end
                      && (per_reg + `MVST_ONE16) < fmax_period;
  logic [3:0] idx_final;
  logic fvo_reg, fvo_next;
  always_comb
  begin
    idx_final = idx_next;
    if (fast_cycle && idx_reg < `MVST_IDX_MAX)
    begin
      idx_final = idx_reg + 4'h1;
    end
    // registered so the mode flag never glitches on a decode
    fvo_next = (idx_final == `MVST_IDX_MIN);
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= MVST_IDLE;
      tmr_reg <= `MVST_ZERO16;
      per_reg <= `MVST_ZERO16;
      edges_reg <= 4'h0;
      idx_reg <= `MVST_IDX_RST;
      gate_reg <= 1'b0;
      fvo_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      per_reg <= per_next;
      edges_reg <= edges_next;
      idx_reg <= idx_final;
      gate_reg <= gate_next;
      fvo_reg <= fvo_next;
    end
  end
  assign gate = gate_reg;
  assign valley_index = idx_reg;
  assign first_valley_operation = fvo_reg;

  // ************************************************************
  // checks
  // ************************************************************
  property p_idx_range;
    @(posedge clk) disable iff (!rst_n)
      idx_reg >= `MVST_IDX_MIN && idx_reg <= `MVST_IDX_MAX;
  endproperty
  a_idx_range: assert property (p_idx_range)
    else $error("valley index out of range");
  property p_idx_step;
    @(posedge clk) disable iff (!rst_n)
      idx_reg != $past(idx_reg) |-> $past(start);
  endproperty
  a_idx_step: assert property (p_idx_step)
    else $error("valley index moved outside cycle start");
  property p_gate_only_on;
    @(posedge clk) disable iff (!rst_n)
      $rose(gate_reg) |-> state_reg == MVST_ON;
  endproperty
  a_gate_only_on: assert property (p_gate_only_on)
    else $error("gate rose outside on phase");
  property p_gate_off_off;
    @(posedge clk) disable iff (!rst_n)
      state_reg == MVST_OFF |-> !gate_reg;
  endproperty
  a_gate_off_off: assert property (p_gate_off_off)
    else $error("gate high in off phase");
  property p_min_dec;
    @(posedge clk) disable iff (!rst_n)
      start && state_reg != MVST_IDLE && !fast_cycle
      && per_reg + `MVST_ONE16 >= min_period && idx_reg > `MVST_IDX_MIN
      |=> idx_reg == $past(idx_reg) - 4'h1;
  endproperty
  a_min_dec: assert property (p_min_dec)
    else $error("index not lowered at min frequency");
  property p_max_inc;
    @(posedge clk) disable iff (!rst_n)
      fast_cycle && idx_reg < `MVST_IDX_MAX
      |=> idx_reg == $past(idx_reg) + 4'h1;
  endproperty
  a_max_inc: assert property (p_max_inc)
    else $error("index not raised at max frequency");
endmodule : mvst_timer

// [bench/mvst_zcd_model.sv]
// zero crossing comparator model for the valley timer bench
`timescale 1ns/10ps
module mvst_zcd_model
#(
  parameter int DEMAG = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gate,
  input wire logic ring_en,
  input wire logic [7:0] half,
  output logic zero_crossing_detect
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n || gate)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  end
  // high while current flows, then rings; no ring means no valley ever
  assign zero_crossing_detect = !ring_en || gate || cnt < DEMAG ||
    (((cnt - DEMAG) / half) % 2 == 1);
endmodule : mvst_zcd_model

// [bench/tb_top.sv]
// self-checking testbench for the valley switching timer
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  logic ring_en = 1'b0;
  logic [7:0] half = 8'h08;
  logic [15:0] on_time = 16'h0014;
  logic [15:0] max_period = 16'h0032;
  logic [15:0] min_period = 16'h0028;
  logic [15:0] quarter_osc = 16'h0004;
  logic zcd, gate, fvo;
  logic [3:0] vidx;
  int num_errors = 0;
  int checks_done = 0;
  int hi, per, n;
  always #5 clk = ~clk;
  mvst_timer #(.CW(16)) mvst_timer_i (.clk(clk), .rst_n(rst_n),
    .enable(enable), .on_time(on_time), .max_period(max_period),
    .min_period(min_period), .quarter_osc(quarter_osc),
    .zero_crossing_detect(zcd), .gate(gate), .valley_index(vidx),
    .first_valley_operation(fvo));
  mvst_zcd_model mvst_zcd_model_i (.clk(clk), .rst_n(rst_n), .gate(gate),
    .ring_en(ring_en), .half(half), .zero_crossing_detect(zcd));
  // ************
  // shared tasks
  // ************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // bounded wait until a signal shows lvl; counts cycles spent
  task automatic wait_for(input logic lvl, input logic use_zcd,
    output int c);
    c = 0;
    while ((use_zcd ? zcd : gate) !== lvl)
    begin
      @(posedge clk);
      #1;
      c++;
      if (c > 3000)
      begin
        num_errors++;
        stop_test();
      end
    end
  endtask : wait_for
  task automatic msr;
    wait_for(1'b1, 1'b0, n);
    wait_for(1'b0, 1'b0, hi);
    wait_for(1'b1, 1'b0, per);
    per = per + hi;
  endtask : msr
  task automatic cfg(input logic [15:0] o, m, l, q, input logic [7:0] h,
    input logic r);
    @(posedge clk);
    enable <= 1'b0;
    on_time <= o;
    max_period <= m;
    min_period <= l;
    quarter_osc <= q;
    half <= h;
    ring_en <= r;
    @(posedge clk);
    enable <= 1'b1;
    // let the edge settle before anyone samples gate
    #1;
  endtask : cfg
  // *********
  // scenarios
  // *********
  task automatic t_timeout;
    cfg(16'h0014, 16'h0032, 16'h0028, 16'h0004, 8'h08, 1'b0);
    msr();
    repeat (3)
    begin
      msr();
      chk(16'(hi), 16'h0014);
      chk(16'(per), 16'h0032);
      chk(16'(vidx), 16'h0001);
    end
    $display("done: timeout");
  endtask : t_timeout
  task automatic t_high;
    // ring half period of two: a one-cycle ring never passes the filter
    cfg(16'h000A, 16'h012C, 16'h00FA, 16'h0030, 8'h02, 1'b1);
    repeat (14)
    begin
      msr();
      chk(16'(hi), 16'h000A);
    end
    chk(16'(vidx), 16'h000A);
    chk(16'(fvo), 16'h0000);
    msr();
    chk(16'(vidx), 16'h000A);
    $display("done: high frequency");
  endtask : t_high
  task automatic t_low;
    cfg(16'h0014, 16'h01F4, 16'h0028, 16'h0004, 8'h08, 1'b1);
    repeat (14)
      msr();
    chk(16'(vidx), 16'h0001);
    chk(16'(fvo), 16'h0001);
    chk(16'(per < 40), 16'h0001);
    wait_for(1'b0, 1'b0, n);
    wait_for(1'b0, 1'b1, n);
    wait_for(1'b1, 1'b0, n);
    // quarter wait of four plus one to four cycles of synchroniser
    chk(16'(n > 4 && n <= 8), 16'h0001);
    $display("done: low frequency");
  endtask : t_low
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(16'(gate), 16'h0000);
    chk(16'(vidx), 16'h0001);
    chk(16'(fvo), 16'h0001);
    t_timeout();
    t_high();
    t_low();
    @(posedge clk);
    enable <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(16'(gate), 16'h0000);
    $display("done: disable");
    stop_test();
  end
endmodule : tb_top
